/* File: scsr_serial_control_slave.sv */
// Purpose: Two-wire serial control slave with the first control registers.
// Assumes: scl_in and sda_in are synchronous to clk and glitch free.
// Notes:   The slave never stretches the clock; it only drives data low.
//
// What this block does
// - Strap levels 0..8 select addresses 0x0C to 0x1B in table order.
// - Data line only pulled low or released; pull-up gives high.
// - High-to-low data while clock high starts every transaction.
// - Low-to-high data while clock high stops and returns to idle.
// - Matching address is acknowledged by pulling data low.
// - Mismatched address is not acknowledged; rest of transaction ignored.
// - Each written data byte is acknowledged on the ninth clock.
// - Offset 0x00 holds an address; bit 0 makes it override the strap.
// - Offset 0x01 bit 7 powers down while no control link seen.
// - Offset 0x01 bit 1 resets logic and registers, then self-clears.
// - Offset 0x01 bit 0 resets logic, keeps registers, self-clears.
// - Offset 0x03 bit 7 enables back-channel CRC check; reset 0xD2.
// - Offset 0x03 bit 4 rejects sync pulses under two clocks.
// - Offset 0x03 bit 3 enables bus pass-through.
// - Offset 0x03 bit 1 enables switch to oscillator without pixel clock.
// - Offset 0x03 bit 0 picks rising (1) or falling (0) strobe edge.
`timescale 1ns/10ps
`default_nettype none
module scsr_serial_control_slave (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Serial bus pins
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_n,
    // Address strap level, 0 to 8
    input  wire logic [3:0]        address_strap_input,
    // Control channel link status
    input  wire logic              link_detected,
    // Video control inputs and filtered outputs
    input  wire scsr_pkg::scsr_video_t video_in,
    output scsr_pkg::scsr_video_t  video_out,
    // Configuration and status outputs
    output scsr_pkg::scsr_cfg_t    cfg,
    output logic                   power_down,
    output logic                   full_digital_reset,
    output logic                   logic_reset_keep_registers,
    output logic [6:0]             active_address
);
    import scsr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    scsr_core_t s_ff;
    scsr_core_t nxt_s;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // strap address table
    function automatic logic [6:0] strap_addr(input logic [3:0] lvl);
        logic [6:0] a;
        a = SCSR_STRAP_ADDR[0];
        if (lvl < 4'(SCSR_STRAP_LEVELS))
            a = SCSR_STRAP_ADDR[lvl];
        return a;
    endfunction : strap_addr

    function automatic logic [7:0] rd_mux(input scsr_core_t c);
        logic [7:0] d;
        d = 8'h00;
        unique case (c.ptr)
            SCSR_OFS_ADDR_SEL: d = c.reg_addr_sel;
            SCSR_OFS_RST_PWR:  d = c.reg_rst_pwr;
            SCSR_OFS_GEN_CFG:  d = c.reg_gen_cfg;
            default:           d = 8'h00;
        endcase
        return d;
    endfunction : rd_mux

    // ------------------------------------------------------------
    // Bus condition detection
    // ------------------------------------------------------------
    assign scl_rise  = !s_ff.scl_q && scl_in;
    assign scl_fall  = s_ff.scl_q && !scl_in;
    assign bus_start = s_ff.scl_q && scl_in && s_ff.sda_q && !sda_in;
    assign bus_stop  = s_ff.scl_q && scl_in && !s_ff.sda_q && sda_in;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] rdata;
        rdata = rd_mux(s_ff);
        nxt_s = s_ff;
        nxt_s.scl_q     = scl_in;
        nxt_s.sda_q     = sda_in;
        nxt_s.full_rst  = 1'b0;
        nxt_s.logic_rst = 1'b0;
        nxt_s.act_addr  = s_ff.reg_addr_sel[SCSR_ADDR_OVR_BIT]
                        ? s_ff.reg_addr_sel[7:1]
                        : strap_addr(address_strap_input);
        nxt_s.pwr_dn    = s_ff.reg_rst_pwr[SCSR_AUTO_PD_BIT]
                        && !link_detected;

        if (bus_start)
        begin
            nxt_s.st       = ST_ADDR;
            nxt_s.bitcnt   = 4'h0;
            nxt_s.first    = 1'b1;
            nxt_s.sda_oe_n = 1'b1;
        end
        else if (bus_stop)
        begin
            nxt_s.st       = ST_IDLE;
            nxt_s.sda_oe_n = 1'b1;
        end
        else if (scl_rise)
        begin
            unique case (s_ff.st)
                ST_ADDR, ST_WR:
                begin
                    nxt_s.shreg  = {s_ff.shreg[6:0], sda_in};
                    nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
                end
                ST_RD:
                begin
                    nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
                end
                ST_RD_ACK:
                begin
                    nxt_s.ack_ok = !sda_in;
                end
                default:
                begin
                    nxt_s.bitcnt = s_ff.bitcnt;
                end
            endcase
        end
        else if (scl_fall)
        begin
            unique case (s_ff.st)
                ST_ADDR:
                begin
                    if (s_ff.bitcnt == SCSR_BITS_PER_BYTE)
                    begin
                        if (s_ff.shreg[7:1] == s_ff.act_addr)
                        begin
                            nxt_s.sda_oe_n = 1'b0;
                            nxt_s.rw       = s_ff.shreg[0];
                            nxt_s.st       = ST_ADDR_ACK;
                        end
                        else
                        begin
                            nxt_s.st = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RD_ACK:
                begin
                    if ((s_ff.st == ST_ADDR_ACK && s_ff.rw)
                        || (s_ff.st == ST_RD_ACK && s_ff.ack_ok))
                    begin
                        nxt_s.shreg    = rdata;
                        nxt_s.ptr      = s_ff.ptr + 8'h01;
                        nxt_s.sda_oe_n = rdata[7];
                        nxt_s.bitcnt   = 4'h0;
                        nxt_s.st       = ST_RD;
                    end
                    else
                    begin
                        nxt_s.sda_oe_n = 1'b1;
                        nxt_s.bitcnt   = 4'h0;
                        nxt_s.st       = s_ff.rw ? ST_IGNORE : ST_WR;
                    end
                end
                ST_WR:
                begin
                    if (s_ff.bitcnt == SCSR_BITS_PER_BYTE)
                    begin
                        nxt_s.sda_oe_n = 1'b0;
                        nxt_s.st       = ST_WR_ACK;
                        nxt_s.first    = 1'b0;
                        if (s_ff.first)
                        begin
                            nxt_s.ptr = s_ff.shreg;
                        end
                        else
                        begin
                            nxt_s.ptr = s_ff.ptr + 8'h01;
                            unique case (s_ff.ptr)
                                SCSR_OFS_ADDR_SEL:
                                begin
                                    nxt_s.reg_addr_sel = s_ff.shreg;
                                end
                                SCSR_OFS_RST_PWR:
                                begin
                                    nxt_s.logic_rst =
                                        s_ff.shreg[SCSR_LOGIC_RST_BIT];
                                    nxt_s.reg_rst_pwr = SCSR_RST_RST_PWR;
                                    nxt_s.reg_rst_pwr[SCSR_AUTO_PD_BIT] =
                                        s_ff.shreg[SCSR_AUTO_PD_BIT];
                                    if (s_ff.shreg[SCSR_FULL_RST_BIT])
                                    begin
                                        nxt_s.full_rst     = 1'b1;
                                        nxt_s.reg_addr_sel =
                                            SCSR_RST_ADDR_SEL;
                                        nxt_s.reg_rst_pwr  =
                                            SCSR_RST_RST_PWR;
                                        nxt_s.reg_gen_cfg  =
                                            SCSR_RST_GEN_CFG;
                                    end
                                end
                                SCSR_OFS_GEN_CFG:
                                begin
                                    nxt_s.reg_gen_cfg = s_ff.shreg;
                                end
                                default:
                                begin
                                    nxt_s.reg_gen_cfg = s_ff.reg_gen_cfg;
                                end
                            endcase
                        end
                    end
                end
                ST_WR_ACK:
                begin
                    nxt_s.sda_oe_n = 1'b1;
                    nxt_s.bitcnt   = 4'h0;
                    nxt_s.st       = ST_WR;
                end
                ST_RD:
                begin
                    if (s_ff.bitcnt == SCSR_BITS_PER_BYTE)
                    begin
                        nxt_s.sda_oe_n = 1'b1;
                        nxt_s.st       = ST_RD_ACK;
                    end
                    else
                    begin
                        nxt_s.shreg    = {s_ff.shreg[6:0], 1'b0};
                        nxt_s.sda_oe_n = s_ff.shreg[6];
                    end
                end
                default:
                begin
                    nxt_s.st = s_ff.st;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_ff <= SCSR_CORE_RST;
        else
            s_ff <= nxt_s;
    end

    // ------------------------------------------------------------
    // Sync pulse filters
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_filt
            scsr_pulse_filter #(
                .MIN_CYC (SCSR_FILT_MIN_CYC)
            ) u_filt (
                .clk     (clk),
                .rst_n   (rst_n),
                .clear   (s_ff.full_rst || s_ff.logic_rst),
                .enable  (s_ff.reg_gen_cfg[SCSR_FILT_EN_BIT]),
                .din     (video_in[gi]),
                .dout    (video_out[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // open-drain data, never driven high
    assign sda_out  = 1'b0;
    assign sda_oe_n = s_ff.sda_oe_n;

    assign cfg.crc_check_en             = s_ff.reg_gen_cfg[SCSR_CRC_EN_BIT];
    assign cfg.sync_filter_en           = s_ff.reg_gen_cfg[SCSR_FILT_EN_BIT];
    assign cfg.pass_through_en          = s_ff.reg_gen_cfg[SCSR_PASS_EN_BIT];
    assign cfg.pclk_auto_switch_en      =
        s_ff.reg_gen_cfg[SCSR_PCLK_AUTO_BIT];
    assign cfg.pixel_strobe_edge_select =
        s_ff.reg_gen_cfg[SCSR_EDGE_SEL_BIT];

    assign power_down                 = s_ff.pwr_dn;
    assign full_digital_reset         = s_ff.full_rst;
    assign logic_reset_keep_registers = s_ff.logic_rst;
    assign active_address             = s_ff.act_addr;

endmodule : scsr_serial_control_slave
`default_nettype wire

/* File: scsr_pkg.sv */
// Purpose: Shared constants and types of the serial control slave.
// Assumes: One 50 MHz clock; bus pins sampled synchronously.
// Notes:   Register offsets, field positions and reset values live here.
package scsr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SCSR_OFS_ADDR_SEL = 8'h00;
    localparam logic [7:0] SCSR_OFS_RST_PWR  = 8'h01;
    localparam logic [7:0] SCSR_OFS_GEN_CFG  = 8'h03;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SCSR_ADDR_OVR_BIT  = 0;
    localparam int SCSR_AUTO_PD_BIT   = 7;
    localparam int SCSR_FULL_RST_BIT  = 1;
    localparam int SCSR_LOGIC_RST_BIT = 0;
    localparam int SCSR_CRC_EN_BIT    = 7;
    localparam int SCSR_FILT_EN_BIT   = 4;
    localparam int SCSR_PASS_EN_BIT   = 3;
    localparam int SCSR_PCLK_AUTO_BIT = 1;
    localparam int SCSR_EDGE_SEL_BIT  = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SCSR_RST_ADDR_SEL = 8'h00;
    localparam logic [7:0] SCSR_RST_RST_PWR  = 8'h00;
    localparam logic [7:0] SCSR_RST_GEN_CFG  = 8'hD2;

    // ------------------------------------------------------------
    // Strap levels and their slave addresses, level 8 first
    // ------------------------------------------------------------
    localparam int SCSR_STRAP_LEVELS = 9;
    localparam logic [8:0][6:0] SCSR_STRAP_ADDR = {
        7'h1B, 7'h15, 7'h14, 7'h13, 7'h10, 7'h0F, 7'h0E, 7'h0D, 7'h0C
    };

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SCSR_FILT_MIN_CYC = 2;
    localparam logic [3:0] SCSR_BITS_PER_BYTE = 4'h8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK,
        ST_RD, ST_RD_ACK, ST_IGNORE
    } scsr_bus_state_t;

    typedef struct packed {
        logic de;
        logic hs;
        logic vs;
    } scsr_video_t;

    typedef struct packed {
        logic crc_check_en;
        logic sync_filter_en;
        logic pass_through_en;
        logic pclk_auto_switch_en;
        logic pixel_strobe_edge_select;
    } scsr_cfg_t;

    typedef struct packed {
        scsr_bus_state_t st;
        logic [3:0]      bitcnt;
        logic [7:0]      shreg;
        logic [7:0]      ptr;
        logic            first;
        logic            rw;
        logic            ack_ok;
        logic            sda_oe_n;
        logic            scl_q;
        logic            sda_q;
        logic [7:0]      reg_addr_sel;
        logic [7:0]      reg_rst_pwr;
        logic [7:0]      reg_gen_cfg;
        logic [6:0]      act_addr;
        logic            full_rst;
        logic            logic_rst;
        logic            pwr_dn;
    } scsr_core_t;

    localparam scsr_core_t SCSR_CORE_RST = '{
        st:           ST_IDLE,
        bitcnt:       4'h0,
        shreg:        8'h00,
        ptr:          8'h00,
        first:        1'b0,
        rw:           1'b0,
        ack_ok:       1'b0,
        sda_oe_n:     1'b1,
        scl_q:        1'b1,
        sda_q:        1'b1,
        reg_addr_sel: SCSR_RST_ADDR_SEL,
        reg_rst_pwr:  SCSR_RST_RST_PWR,
        reg_gen_cfg:  SCSR_RST_GEN_CFG,
        act_addr:     7'h0C,
        full_rst:     1'b0,
        logic_rst:    1'b0,
        pwr_dn:       1'b0
    };

endpackage : scsr_pkg

/* File: scsr_pulse_filter.sv */
// Purpose: Rejects input pulses shorter than a minimum number of cycles.
// Assumes: Input sampled on every rising clock edge.
// Notes:   When disabled the input passes with one cycle of latency.
`timescale 1ns/10ps
`default_nettype none
module scsr_pulse_filter #(
    parameter int MIN_CYC = 2
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    input  wire logic clear,
    input  wire logic enable,
    // Data
    input  wire logic din,
    output logic      dout
);
    import scsr_pkg::*;

    typedef struct packed {
        logic       out;
        logic [3:0] cnt;
    } scsr_filt_t;

    localparam logic [3:0] LAST_CNT = 4'(MIN_CYC - 1);

    scsr_filt_t s_ff;
    scsr_filt_t nxt_s;

    always_comb
    begin
        nxt_s = s_ff;
        if (clear)
        begin
            nxt_s = '0;
        end
        else if (!enable)
        begin
            nxt_s.out = din;
            nxt_s.cnt = 4'h0;
        end
        else if (din == s_ff.out)
        begin
            nxt_s.cnt = 4'h0;
        end
        else if (s_ff.cnt >= LAST_CNT)
        begin
            nxt_s.out = din;
            nxt_s.cnt = 4'h0;
        end
        else
        begin
            nxt_s.cnt = s_ff.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign dout = s_ff.out;

endmodule : scsr_pulse_filter
`default_nettype wire

/* File: scsr_slave_properties.sv */
// Purpose: Port-level properties of the serial control slave.
// Assumes: One clock domain, reset active low.
// Notes:   Bound to every instance of the slave.
`timescale 1ns/10ps
`default_nettype none
module scsr_slave_properties (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    // Watched ports
    input wire logic                  scl_in,
    input wire logic                  sda_in,
    input wire logic                  sda_out,
    input wire logic                  sda_oe_n,
    input wire logic                  link_detected,
    input wire scsr_pkg::scsr_video_t video_in,
    input wire scsr_pkg::scsr_video_t video_out,
    input wire scsr_pkg::scsr_cfg_t   cfg,
    input wire logic                  power_down,
    input wire logic                  full_digital_reset,
    input wire logic                  logic_reset_keep_registers
);
    import scsr_pkg::*;
    logic quiet;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // A reset pulse clears the sync filter, so its outputs restart.
    assign quiet = !full_digital_reset && !logic_reset_keep_registers;

    drive_low_only_a:
        assert property (sda_out == 1'h0) else $error("data driven high");
    ack_on_low_clk_a:
        assert property ($changed(sda_oe_n) |-> !$past(scl_in))
        else $error("data line moved while clock high");
    stop_release_a:
        assert property (scl_in && $past(scl_in) && $rose(sda_in)
                         |=> sda_oe_n [*3])
        else $error("data line held after stop");
    power_gate_a:
        assert property ($past(link_detected) |-> !power_down)
        else $error("power down with link present");
    full_pulse_a:
        assert property (full_digital_reset |=> !full_digital_reset)
        else $error("full reset pulse too long");
    keep_pulse_a:
        assert property ($rose(logic_reset_keep_registers)
                         |=> $fell(logic_reset_keep_registers))
        else $error("logic reset pulse too long");
    full_defaults_a:
        assert property (full_digital_reset |-> ##[0:3] cfg == 5'h1A)
        else $error("config not back to defaults");
    filter_pass_a:
        assert property ((cfg.sync_filter_en && quiet && $stable(video_in))
                         [*4] |-> video_out == video_in)
        else $error("filtered sync lost a long pulse");
    filter_off_a:
        assert property ((!cfg.sync_filter_en && quiet && $stable(video_in))
                         [*2] |-> video_out == video_in)
        else $error("unfiltered sync late");
endmodule : scsr_slave_properties

bind scsr_serial_control_slave scsr_slave_properties props_u (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .link_detected(link_detected),
    .video_in(video_in), .video_out(video_out), .cfg(cfg),
    .power_down(power_down), .full_digital_reset(full_digital_reset),
    .logic_reset_keep_registers(logic_reset_keep_registers));
`default_nettype wire

/* File: scsr_host_model.sv */
// Purpose: Host bus master driving the serial clock and data lines.
// Assumes: Pull-up on both lines; phases of at least two clk cycles.
// Notes:   slow stretches every phase to act as a sluggish host.
`timescale 1ns/10ps
`default_nettype none
module scsr_host_model (
    // Clock
    input  wire logic clk,
    // Bus lines
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_rel
);
    int slow = 0;

    initial
    begin
        scl     = 1'h1;
        sda_rel = 1'h1;
    end

    task automatic step(input logic c, input logic d, input int n);
        @(posedge clk);
        scl     <= c;
        sda_rel <= d;
        repeat (n - 1 + slow) @(posedge clk);
    endtask : step

    task automatic bitx(input logic b, output logic r);
        step(1'h0, sda_rel, 2);
        step(1'h0, b, 2);
        step(1'h1, b, 3);
        r = sda_in;
    endtask : bitx

    task automatic start();
        step(1'h0, sda_rel, 2);
        step(1'h0, 1'h1, 2);
        step(1'h1, 1'h1, 3);
        step(1'h1, 1'h0, 3);
    endtask : start

    task automatic stop();
        step(1'h0, sda_rel, 2);
        step(1'h0, 1'h0, 2);
        step(1'h1, 1'h0, 3);
        step(1'h1, 1'h1, 3);
    endtask : stop

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(b[i], r);
        bitx(1'h1, r);
        ack = !r;
    endtask : wbyte

    task automatic rbyte(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 0; i < 8; i++)
        begin
            bitx(1'h1, r);
            b = {b[6:0], r};
        end
        bitx(!more, r);
    endtask : rbyte
endmodule : scsr_host_model
`default_nettype wire

/* File: scsr_serial_control_slave_tb.sv */
// Purpose: Self-checking bench of the serial control slave.
// Assumes: clk also stands in for the pixel clock.
// Notes:   Registers are mirrored here and read back over the bus.
`timescale 1ns/10ps
`default_nettype none
module scsr_serial_control_slave_tb;
    import scsr_pkg::*;
    logic        clk = 1'h0;
    logic        rst_n, scl, sda_rel, sda_w, sda_out, sda_oe_n, link;
    logic        power_down, frst, lrst;
    logic [3:0]  strap;
    logic [6:0]  act_addr;
    logic [7:0]  m0, m1, m3, ptr, v;
    scsr_video_t video_in, video_out;
    scsr_cfg_t   cfg;
    logic [6:0]  tbl [9] = '{7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h10,
                             7'h13, 7'h14, 7'h15, 7'h1B};
    int failures = 0, checks_done = 0, seed = 32'hE4D64B1A;
    int frst_cnt = 0, lrst_cnt = 0, frst_exp = 0, lrst_exp = 0;

    always #10 clk = ~clk;
    // Open drain: any party pulling low wins over the pull-up.
    assign sda_w = sda_rel & (sda_oe_n | sda_out);

    scsr_serial_control_slave dut_u (.clk(clk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .address_strap_input(strap),
        .link_detected(link), .video_in(video_in), .video_out(video_out),
        .cfg(cfg), .power_down(power_down), .full_digital_reset(frst),
        .logic_reset_keep_registers(lrst), .active_address(act_addr));
    scsr_host_model host_u (.clk(clk), .sda_in(sda_w), .scl(scl),
        .sda_rel(sda_rel));

    always @(negedge clk)
    begin
        frst_cnt += frst;
        lrst_cnt += lrst;
    end

    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    function automatic logic [6:0] exp_addr();
        return m0[0] ? m0[7:1] : (strap < 4'h9 ? tbl[strap] : 7'h0C);
    endfunction : exp_addr

    function automatic logic [7:0] mdl_rd(logic [7:0] p);
        return p == 8'h00 ? m0 : p == 8'h01 ? m1 : p == 8'h03 ? m3 : 8'h00;
    endfunction : mdl_rd

    task automatic mdl_wr(logic [7:0] d);
        if (ptr == 8'h00)
            m0 = d;
        if (ptr == 8'h03)
            m3 = d;
        if (ptr == 8'h01)
        begin
            m1 = d & 8'h80;
            lrst_exp += d[0];
            frst_exp += d[1];
            if (d[1])
                {m0, m1, m3} = 24'h0000D2;
        end
        ptr++;
    endtask : mdl_wr

    task automatic wr(logic [6:0] a, logic [7:0] d[$], logic stp);
        logic ack;
        logic hit;
        hit = (a === exp_addr());
        host_u.start();
        host_u.wbyte({a, 1'h0}, ack);
        chk("address ack", ack, hit);
        foreach (d[i])
        begin
            host_u.wbyte(d[i], ack);
            chk("data ack", ack, hit);
            if (hit && i == 0)
                ptr = d[i];
            else if (hit)
                mdl_wr(d[i]);
        end
        if (stp)
            host_u.stop();
    endtask : wr

    task automatic rd(logic [6:0] a, int n);
        logic       ack;
        logic [7:0] b;
        host_u.start();
        host_u.wbyte({a, 1'h1}, ack);
        chk("read ack", ack, 1'h1);
        for (int i = 0; i < n; i++)
        begin
            host_u.rbyte(i < n - 1, b);
            chk("read data", b, mdl_rd(ptr));
            ptr++;
        end
        host_u.stop();
    endtask : rd

    task automatic give_verdict();
        $display("Checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (60000) @(posedge clk);
        failures++;
        give_verdict();
    end

    initial
    begin
        {rst_n, link, strap, video_in} = 9'h080;
        {m0, m1, m3, ptr} = 32'h0000D200;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        for (int s = 0; s < 11; s++)
        begin
            @(posedge clk);
            strap <= (s < 10) ? 4'(s) : 4'($unsigned($random(seed)) % 9);
            tick(3);
            chk("strap address", act_addr, exp_addr());
        end
        wr(exp_addr(), '{8'h01}, 1'h0);
        rd(exp_addr(), 3);
        wr(exp_addr() ^ 7'h01, '{8'h03, 8'h00}, 1'h1);
        for (int k = 0; k < 4; k++)
        begin
            v = 8'($random(seed));
            host_u.slow = k;
            wr(exp_addr(), '{8'h03, v, 8'h5A}, 1'h1);
            chk("config", cfg, {v[7], v[4], v[3], v[1], v[0]});
            wr(exp_addr(), '{8'h03}, 1'h0);
            rd(exp_addr(), 2);
        end
        host_u.slow = 0;
        v = {7'($random(seed)), 1'h1};
        wr(exp_addr(), '{8'h00, v}, 1'h1);
        chk("override address", act_addr, v[7:1]);
        wr(v[7:1], '{8'h00}, 1'h0);
        rd(v[7:1], 1);
        wr(v[7:1], '{8'h00, 8'h00}, 1'h1);
        chk("strap address", act_addr, exp_addr());
        for (int l = 0; l < 4; l++)
        begin
            wr(exp_addr(), '{8'h01, {l[1], 7'h00}}, 1'h1);
            @(posedge clk);
            link <= l[0];
            tick(3);
            chk("power down", power_down, l[1] & !l[0]);
        end
        wr(exp_addr(), '{8'h01, 8'h81}, 1'h1);
        wr(exp_addr(), '{8'h01}, 1'h0);
        rd(exp_addr(), 3);
        wr(exp_addr(), '{8'h01, 8'h02}, 1'h1);
        wr(exp_addr(), '{8'h01}, 1'h0);
        rd(exp_addr(), 3);
        chk("logic reset", 8'(lrst_cnt), 8'(lrst_exp));
        chk("full reset", 8'(frst_cnt), 8'(frst_exp));
        for (int p = 0; p < 12; p++)
        begin
            @(posedge clk);
            video_in <= (p == 3) ? 3'h5 : ((p > 7) ? 3'h2 : 3'h0);
            #1;
            if (p < 9 || p == 11)
                chk("filtered sync", video_out, (p > 9) ? 3'h2 : 3'h0);
        end
        wr(exp_addr(), '{8'h03, 8'hC2}, 1'h1);
        for (int p = 0; p < 20; p++)
        begin
            @(posedge clk);
            v[2:0] = video_in;
            video_in <= 3'($random(seed));
            #1;
            chk("unfiltered sync", video_out, v[2:0]);
        end
        give_verdict();
    end
endmodule : scsr_serial_control_slave_tb
`default_nettype wire
